// File: wake_status_pkg.sv
// Register map, bit positions and mode codes of the wake, level and switch status bank
package wake_status_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IO_PINS = 2;
  localparam int unsigned WAKE_INS = 3;
  localparam int unsigned HS_SWITCHES = 4;
  localparam int unsigned PIN_SYNC_W = 7;

  // Register offsets on the configuration serial interface
  localparam logic [ADDR_W-1:0] ADDR_PIN_WAKE = 7'h47;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 7'h48;
  localparam logic [ADDR_W-1:0] ADDR_HS_OVERLOAD = 7'h54;
  localparam logic [ADDR_W-1:0] ADDR_HS_OPEN_LOAD = 7'h55;

  // Bit positions
  localparam int unsigned BIT_IO1_WAKE = 4;
  localparam int unsigned BIT_IO2_WAKE = 5;
  localparam int unsigned BIT_STRAP = 7;
  localparam int unsigned BIT_PULLUP = 6;
  localparam int unsigned BIT_IO2_LVL = 5;
  localparam int unsigned BIT_IO1_LVL = 4;
  localparam int unsigned BIT_WAKE_LVL_LO = 0;
  localparam int unsigned BIT_HS_LO = 0;

  // Reset values and reserved masks
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
  localparam logic [DATA_W-1:0] RSV_PIN_WAKE = 8'hCF;
  localparam logic [DATA_W-1:0] RSV_LEVEL = 8'h08;
  localparam logic [DATA_W-1:0] RSV_HS = 8'hF0;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h1,
    MODE_STOP = 3'h2,
    MODE_OTHER = 3'h4
  } sbcMode_t;

  typedef enum logic [3:0] {
    IO_FN_OFF = 4'h1,
    IO_FN_WAKE = 4'h2,
    IO_FN_LOW_SIDE = 4'h4,
    IO_FN_HIGH_SIDE = 4'h8
  } ioFunction_t;

endpackage

// File: flag_bank_if.sv
// Carrier between the status bank and one read-to-clear flag group
`timescale 1ns/10ps
`default_nettype none
interface flag_bank_if #(parameter int unsigned W = 4);
  logic [W-1:0] setEv;
  logic readClr;
  logic softClr;
  logic [W-1:0] flags;
  modport owner (input setEv, input readClr, input softClr, output flags);
  modport user (output setEv, output readClr, output softClr, input flags);
endinterface
`default_nettype wire

// File: sync_2ff.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async,
  output var logic [W-1:0] synced
);

  logic [W-1:0] stage1_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      synced <= '0;
    end else begin
      stage1_q <= async;
      synced <= stage1_q;
    end
  end

endmodule
`default_nettype wire

// File: rc_flags.sv
// Group of sticky read-to-clear event flags
`timescale 1ns/10ps
`default_nettype none
module rc_flags #(
  parameter int unsigned W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  flag_bank_if.owner bank
);

  // A new event in the read-clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank.flags <= '0;
    end else if (bank.softClr) begin
      bank.flags <= '0;
    end else if (bank.readClr) begin
      bank.flags <= bank.setEv;
    end else begin
      bank.flags <= bank.flags | bank.setEv;
    end
  end

endmodule
`default_nettype wire

// File: wake_level_switch_status_regs.sv
// Wake, input level and high-side switch status register bank
//
// What this block does
// - Reserved bits of all four status registers always read back as zero.
// - Pin wake register holds io pin 2 and 1 wake flags at bits 5, 4.
// - Pin wake register clears on soft reset; restart keeps both pin flags.
// - Level register bits 5, 4 show io pin 2 and 1 levels.
// - Level register bits 2, 1, 0 show wake inputs 3, 2, 1.
// - Io pin levels refresh in Normal and Stop when selected and used as wake or switch.
// - Cyclically sensed wake inputs hold their last sample, rewritten per sample.
// - Io pin levels never follow a cyclic sampling strobe.
// - A selected io pin shows its real level in Normal and Stop, even when used as switch.
// - Level bit 7 shows the mode strap: 1 development, 0 user mode.
// - Level bit 6 reads 1 when an interrupt pin pull-up is detected.
// - Soft reset clears level bits 5 and 4.
// - Overload register bits 3..0 flag overcurrent or overtemperature per switch.
// - Open-load register bits 3..0 flag open load per switch.
// - Switch registers clear on soft reset; restart keeps the four flags.
`timescale 1ns/10ps
`default_nettype none
module wake_level_switch_status_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic softRst,
  input wire logic restartPulse,
  input wire logic rdEn,
  input wire logic [wake_status_pkg::ADDR_W-1:0] rdAddr,
  output var logic [wake_status_pkg::DATA_W-1:0] rdData_q,
  output var logic rdValid_q,
  input wire logic [wake_status_pkg::WAKE_INS-1:0] wakeInPin,
  input wire logic [wake_status_pkg::IO_PINS-1:0] ioPin,
  input wire logic modeStrapPin,
  input wire logic intPullupSense,
  input wire wake_status_pkg::sbcMode_t sbcMode,
  input wire wake_status_pkg::ioFunction_t io1Function,
  input wire wake_status_pkg::ioFunction_t io2Function,
  input wire logic [wake_status_pkg::IO_PINS-1:0] ioSelected,
  input wire logic [wake_status_pkg::WAKE_INS-1:0] wakeCyclic,
  input wire logic [wake_status_pkg::WAKE_INS-1:0] wakeSampleStrobe,
  input wire logic [wake_status_pkg::IO_PINS-1:0] ioWakeEvent,
  input wire logic [wake_status_pkg::HS_SWITCHES-1:0] hsOverloadEvent,
  input wire logic [wake_status_pkg::HS_SWITCHES-1:0] hsOpenLoadEvent
);

  logic [wake_status_pkg::PIN_SYNC_W-1:0] pinSync;
  logic [wake_status_pkg::WAKE_INS-1:0] wakeSync;
  logic [wake_status_pkg::IO_PINS-1:0] ioSync;
  logic strapSync;
  logic pullupSync;
  logic [wake_status_pkg::IO_PINS-1:0] ioLvlUpd;
  logic [wake_status_pkg::IO_PINS-1:0] ioLvl_q;
  logic [wake_status_pkg::WAKE_INS-1:0] wakeLvl_q;
  logic [wake_status_pkg::DATA_W-1:0] levelWord;
  logic [wake_status_pkg::DATA_W-1:0] wakeWord;
  logic [wake_status_pkg::DATA_W-1:0] ovlWord;
  logic [wake_status_pkg::DATA_W-1:0] olWord;
  logic [wake_status_pkg::DATA_W-1:0] rdMux;
  logic [wake_status_pkg::ADDR_W-1:0] lastAddr_q;
  logic modeAwake;
  logic rdWake;
  logic rdOvl;
  logic rdOl;
  logic rdLevel;

  flag_bank_if #(.W(wake_status_pkg::IO_PINS)) wakeBank ();
  flag_bank_if #(.W(wake_status_pkg::HS_SWITCHES)) ovlBank ();
  flag_bank_if #(.W(wake_status_pkg::HS_SWITCHES)) olBank ();

  // Pins come from outside the clock domain
  sync_2ff #(.W(wake_status_pkg::PIN_SYNC_W)) u_pinSync (
    .clk(clk),
    .rst_n(rst_n),
    .async({modeStrapPin, intPullupSense, ioPin, wakeInPin}),
    .synced(pinSync)
  );

  assign wakeSync = pinSync[wake_status_pkg::WAKE_INS-1:0];
  assign ioSync = pinSync[wake_status_pkg::WAKE_INS +: wake_status_pkg::IO_PINS];
  assign pullupSync = pinSync[wake_status_pkg::PIN_SYNC_W-2];
  assign strapSync = pinSync[wake_status_pkg::PIN_SYNC_W-1];

  // Address decode of the read strobe
  assign rdWake = rdEn && (rdAddr == wake_status_pkg::ADDR_PIN_WAKE);
  assign rdLevel = rdEn && (rdAddr == wake_status_pkg::ADDR_LEVEL);
  assign rdOvl = rdEn && (rdAddr == wake_status_pkg::ADDR_HS_OVERLOAD);
  assign rdOl = rdEn && (rdAddr == wake_status_pkg::ADDR_HS_OPEN_LOAD);

  // Restart is not wired to the flag groups: only power-on, soft reset and a read clear them
  assign wakeBank.setEv = ioWakeEvent;
  assign wakeBank.readClr = rdWake;
  assign wakeBank.softClr = softRst;
  assign ovlBank.setEv = hsOverloadEvent;
  assign ovlBank.readClr = rdOvl;
  assign ovlBank.softClr = softRst;
  assign olBank.setEv = hsOpenLoadEvent;
  assign olBank.readClr = rdOl;
  assign olBank.softClr = softRst;

  rc_flags #(.W(wake_status_pkg::IO_PINS)) u_wakeFlags (
    .clk(clk),
    .rst_n(rst_n),
    .bank(wakeBank)
  );

  rc_flags #(.W(wake_status_pkg::HS_SWITCHES)) u_ovlFlags (
    .clk(clk),
    .rst_n(rst_n),
    .bank(ovlBank)
  );

  rc_flags #(.W(wake_status_pkg::HS_SWITCHES)) u_olFlags (
    .clk(clk),
    .rst_n(rst_n),
    .bank(olBank)
  );

  // Io pin level refresh qualifier
  assign modeAwake = (sbcMode == wake_status_pkg::MODE_NORMAL) ||
                     (sbcMode == wake_status_pkg::MODE_STOP);
  assign ioLvlUpd[0] = ioSelected[0] && modeAwake &&
                       (io1Function != wake_status_pkg::IO_FN_OFF);
  assign ioLvlUpd[1] = ioSelected[1] && modeAwake &&
                       (io2Function != wake_status_pkg::IO_FN_OFF);

  // Io pins have no cyclic sensing, so the sample strobes never reach them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioLvl_q <= '0;
    end else if (softRst) begin
      ioLvl_q <= '0;
    end else begin
      for (int i = 0; i < wake_status_pkg::IO_PINS; i++) begin
        if (ioLvlUpd[i]) begin
          ioLvl_q[i] <= ioSync[i];
        end
      end
    end
  end

  // Wake input levels: live, or held between cyclic samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeLvl_q <= '0;
    end else begin
      for (int i = 0; i < wake_status_pkg::WAKE_INS; i++) begin
        if (!wakeCyclic[i] || wakeSampleStrobe[i]) begin
          wakeLvl_q[i] <= wakeSync[i];
        end
      end
    end
  end

  // Register images; bits not written stay at the reserved zero
  always_comb begin
    levelWord = wake_status_pkg::READ_IDLE;
    levelWord[wake_status_pkg::BIT_STRAP] = strapSync;
    levelWord[wake_status_pkg::BIT_PULLUP] = pullupSync;
    levelWord[wake_status_pkg::BIT_IO2_LVL] = ioLvl_q[1];
    levelWord[wake_status_pkg::BIT_IO1_LVL] = ioLvl_q[0];
    levelWord[wake_status_pkg::BIT_WAKE_LVL_LO +: wake_status_pkg::WAKE_INS] =
      wakeLvl_q;
  end

  always_comb begin
    wakeWord = wake_status_pkg::READ_IDLE;
    wakeWord[wake_status_pkg::BIT_IO1_WAKE] = wakeBank.flags[0];
    wakeWord[wake_status_pkg::BIT_IO2_WAKE] = wakeBank.flags[1];
  end

  always_comb begin
    ovlWord = wake_status_pkg::READ_IDLE;
    ovlWord[wake_status_pkg::BIT_HS_LO +: wake_status_pkg::HS_SWITCHES] =
      ovlBank.flags;
    olWord = wake_status_pkg::READ_IDLE;
    olWord[wake_status_pkg::BIT_HS_LO +: wake_status_pkg::HS_SWITCHES] =
      olBank.flags;
  end

  // Unmapped addresses read as zero
  always_comb begin
    case (rdAddr)
      wake_status_pkg::ADDR_PIN_WAKE: rdMux = wakeWord;
      wake_status_pkg::ADDR_LEVEL: rdMux = levelWord;
      wake_status_pkg::ADDR_HS_OVERLOAD: rdMux = ovlWord;
      wake_status_pkg::ADDR_HS_OPEN_LOAD: rdMux = olWord;
      default: rdMux = wake_status_pkg::READ_IDLE;
    endcase
  end

  // Data is captured in the same edge that clears the flags, so nothing is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= wake_status_pkg::READ_IDLE;
    end else if (rdEn) begin
      rdData_q <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastAddr_q <= '0;
    end else if (rdEn) begin
      lastAddr_q <= rdAddr;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reserved_wake_zero: assert property (
    rdValid_q && (lastAddr_q == wake_status_pkg::ADDR_PIN_WAKE)
    |-> (rdData_q & wake_status_pkg::RSV_PIN_WAKE) == 8'h00
  ) else $error("pin wake reserved bits not zero");

  a_reserved_level_zero: assert property (
    rdValid_q && (lastAddr_q == wake_status_pkg::ADDR_LEVEL)
    |-> (rdData_q & wake_status_pkg::RSV_LEVEL) == 8'h00
  ) else $error("level reserved bit not zero");

  a_reserved_switch_zero: assert property (
    rdValid_q && ((lastAddr_q == wake_status_pkg::ADDR_HS_OVERLOAD) ||
                  (lastAddr_q == wake_status_pkg::ADDR_HS_OPEN_LOAD))
    |-> (rdData_q & wake_status_pkg::RSV_HS) == 8'h00
  ) else $error("switch reserved bits not zero");

  a_wake_flag_set: assert property (
    ioWakeEvent[1] && !softRst
    |=> wakeBank.flags[1]
  ) else $error("io pin 2 wake event not flagged");

  a_wake_read_bit: assert property (
    rdWake |=> rdData_q[wake_status_pkg::BIT_IO1_WAKE] == $past(wakeBank.flags[0])
  ) else $error("io pin 1 wake flag misplaced");

  a_restart_keeps_flags: assert property (
    restartPulse && !softRst && !rdEn
    |=> wakeBank.flags == ($past(wakeBank.flags) | $past(ioWakeEvent)) &&
        olBank.flags == ($past(olBank.flags) | $past(hsOpenLoadEvent))
  ) else $error("restart altered kept flags");

  a_soft_clears_all: assert property (
    softRst |=> wakeBank.flags == '0 && ovlBank.flags == '0 &&
                olBank.flags == '0 && ioLvl_q == '0
  ) else $error("soft reset left status set");

  a_level_io_bits: assert property (
    rdLevel |=> rdData_q[wake_status_pkg::BIT_IO2_LVL] == $past(ioLvl_q[1]) &&
                rdData_q[wake_status_pkg::BIT_IO1_LVL] == $past(ioLvl_q[0])
  ) else $error("io level bits misplaced");

  a_wake_level_live: assert property (
    !wakeCyclic[2] |=> wakeLvl_q[2] == $past(wakeSync[2])
  ) else $error("wake input 3 level not live");

  a_io_level_follow: assert property (
    ioLvlUpd[0] && !softRst |=> ioLvl_q[0] == $past(ioSync[0])
  ) else $error("io pin 1 level not refreshed");

  a_cyclic_hold: assert property (
    wakeCyclic[1] && !wakeSampleStrobe[1] |=> $stable(wakeLvl_q[1])
  ) else $error("cyclic wake level changed between samples");

  a_io_no_cyclic: assert property (
    !ioLvlUpd[1] && !softRst |=> $stable(ioLvl_q[1])
  ) else $error("io pin 2 level moved without refresh");

  a_switch_level_shown: assert property (
    ioSelected[0] && (sbcMode == wake_status_pkg::MODE_NORMAL) &&
    (io1Function == wake_status_pkg::IO_FN_HIGH_SIDE) && !softRst
    |=> ioLvl_q[0] == $past(ioSync[0])
  ) else $error("switch pin level hidden");

  a_strap_pullup_bits: assert property (
    rdLevel |=> rdData_q[wake_status_pkg::BIT_STRAP] == $past(strapSync) &&
                rdData_q[wake_status_pkg::BIT_PULLUP] == $past(pullupSync)
  ) else $error("strap or pull-up bit wrong");

  a_pullup_stable_read: assert property (
    rdLevel ##1 rdLevel && $stable(pullupSync)
    |=> rdData_q[wake_status_pkg::BIT_PULLUP] == $past(pullupSync, 2)
  ) else $error("pull-up bit unstable");

  a_soft_level_clear: assert property (
    softRst ##1 rdLevel
    |=> rdData_q[wake_status_pkg::BIT_IO1_LVL +: wake_status_pkg::IO_PINS] == '0
  ) else $error("soft reset did not clear io levels");

  a_overload_read: assert property (
    rdOvl |=> rdData_q[wake_status_pkg::BIT_HS_LO +: wake_status_pkg::HS_SWITCHES] ==
              $past(ovlBank.flags)
  ) else $error("overload read value wrong");

  a_open_load_set: assert property (
    hsOpenLoadEvent[2] && !softRst
    |=> olBank.flags[2] ##1 (olBank.flags[2] || $past(rdOl) || $past(softRst))
  ) else $error("open load event lost");

  a_read_clears: assert property (
    rdOvl && !softRst |=> ovlBank.flags == $past(hsOverloadEvent)
  ) else $error("read did not clear overload flags");

  a_restart_switch_kept: assert property (
    restartPulse && !softRst && !rdEn
    |=> ovlBank.flags == ($past(ovlBank.flags) | $past(hsOverloadEvent))
  ) else $error("restart altered overload flags");

  // A strobe aimed at the wake inputs must not leak into the io pin 1 level
  a_strobe_skips_io: assert property (
    wakeSampleStrobe != '0 && !ioLvlUpd[0] && !softRst |=> $stable(ioLvl_q[0])
  ) else $error("io pin 1 level followed a sample strobe");

  a_cyclic_sample_taken: assert property (
    wakeCyclic[0] && wakeSampleStrobe[0]
    |=> wakeLvl_q[0] == $past(wakeSync[0])
  ) else $error("cyclic wake sample not stored");

  c_wake_read_clear: cover property (
    ioWakeEvent[0] ##1 rdWake ##1 wakeBank.flags == '0
  );

  c_cyclic_sample: cover property (
    wakeCyclic[0] && wakeSampleStrobe[0] ##1 wakeCyclic[0] [*3]
  );

  c_overload_read: cover property (
    hsOverloadEvent[3] ##[1:4] rdOvl ##1 rdData_q[3]
  );

  c_soft_then_level: cover property (
    softRst ##1 rdLevel
  );

  c_restart_kept: cover property (
    restartPulse && (ovlBank.flags != '0) ##1 rdOvl
  );

endmodule
`default_nettype wire

// File: host_reader.sv
// Host microcontroller model reading the status bank one byte at a time
`timescale 1ns/10ps
`default_nettype none
module host_reader (
  input wire logic clk,
  output logic rdEn,
  output logic [wake_status_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [wake_status_pkg::DATA_W-1:0] rdData_q,
  input wire logic rdValid_q
);
  initial begin
    rdEn = 1'b0;
    rdAddr = 7'h00;
  end

  // Address is inverted once released so a stale value never looks valid
  task automatic readReg(input logic [wake_status_pkg::ADDR_W-1:0] addr,
                         output logic [wake_status_pkg::DATA_W-1:0] data);
    @(negedge clk);
    rdEn = 1'b1;
    rdAddr = addr;
    @(negedge clk);
    rdEn = 1'b0;
    rdAddr = ~addr;
    data = (rdValid_q === 1'b1) ? rdData_q : 8'hxx;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the wake, level and switch status bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic softRst = 1'b0;
  logic restartPulse = 1'b0;
  logic rdEn;
  logic [6:0] rdAddr;
  logic [7:0] rdData_q;
  logic rdValid_q;
  logic [2:0] wakeInPin = 3'h0;
  logic [1:0] ioPin = 2'h0;
  logic modeStrapPin = 1'b0;
  logic intPullupSense = 1'b0;
  wake_status_pkg::sbcMode_t sbcMode = wake_status_pkg::MODE_NORMAL;
  wake_status_pkg::ioFunction_t io1Function = wake_status_pkg::IO_FN_WAKE;
  wake_status_pkg::ioFunction_t io2Function = wake_status_pkg::IO_FN_WAKE;
  logic [1:0] ioSelected = 2'h3;
  logic [2:0] wakeCyclic = 3'h0;
  logic [2:0] wakeSampleStrobe = 3'h0;
  logic [1:0] ioWakeEvent = 2'h0;
  logic [3:0] hsOverloadEvent = 4'h0;
  logic [3:0] hsOpenLoadEvent = 4'h0;
  int errors = 0;
  int nTests = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  wake_level_switch_status_regs dut (
    .clk(clk), .rst_n(rst_n), .softRst(softRst), .restartPulse(restartPulse),
    .rdEn(rdEn), .rdAddr(rdAddr), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .wakeInPin(wakeInPin), .ioPin(ioPin), .modeStrapPin(modeStrapPin),
    .intPullupSense(intPullupSense), .sbcMode(sbcMode), .io1Function(io1Function),
    .io2Function(io2Function), .ioSelected(ioSelected), .wakeCyclic(wakeCyclic),
    .wakeSampleStrobe(wakeSampleStrobe), .ioWakeEvent(ioWakeEvent),
    .hsOverloadEvent(hsOverloadEvent), .hsOpenLoadEvent(hsOpenLoadEvent)
  );

  host_reader host (
    .clk(clk), .rdEn(rdEn), .rdAddr(rdAddr), .rdData_q(rdData_q), .rdValid_q(rdValid_q)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Timeout: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic checkReg(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host.readReg(addr, got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: reg %h got %h expected %h", $time, addr, got, exp);
    end
  endtask

  task automatic pulseEv(input logic [3:0] ov, input logic [3:0] ol, input logic [1:0] io);
    @(negedge clk);
    hsOverloadEvent = ov;
    hsOpenLoadEvent = ol;
    ioWakeEvent = io;
    @(negedge clk);
    hsOverloadEvent = 4'h0;
    hsOpenLoadEvent = 4'h0;
    ioWakeEvent = 2'h0;
  endtask

  // Two sync stages plus capture, with one cycle of margin
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic testReset();
    checkReg(7'h47, 8'h00);
    checkReg(7'h48, 8'h00);
    checkReg(7'h54, 8'h00);
    checkReg(7'h55, 8'h00);
    checkReg(7'h00, 8'h00);
  endtask

  task automatic testSwitchFlags();
    for (int i = 0; i < 4; i++) begin
      pulseEv(4'h1 << i, 4'h0, 2'h0);
      checkReg(7'h54, {4'h0, 4'h1 << i});
      checkReg(7'h54, 8'h00);
      pulseEv(4'h0, 4'h1 << i, 2'h0);
      checkReg(7'h55, {4'h0, 4'h1 << i});
      checkReg(7'h55, 8'h00);
    end
  endtask

  // Event still present at the read edge must survive the clear
  task automatic testSetWins();
    @(negedge clk);
    hsOpenLoadEvent = 4'h1;
    checkReg(7'h55, 8'h01);
    hsOpenLoadEvent = 4'h0;
    checkReg(7'h55, 8'h01);
    checkReg(7'h55, 8'h00);
  endtask

  task automatic testPinWake();
    pulseEv(4'h0, 4'h0, 2'h1);
    checkReg(7'h47, 8'h10);
    pulseEv(4'h0, 4'h0, 2'h2);
    checkReg(7'h47, 8'h20);
    pulseEv(4'h0, 4'h0, 2'h3);
    checkReg(7'h47, 8'h30);
    checkReg(7'h47, 8'h00);
  endtask

  task automatic testLevels();
    modeStrapPin = 1'b1;
    intPullupSense = 1'b1;
    wakeInPin = 3'h5;
    ioPin = 2'h2;
    settle();
    checkReg(7'h48, 8'he5);
    io1Function = wake_status_pkg::IO_FN_HIGH_SIDE;
    io2Function = wake_status_pkg::IO_FN_LOW_SIDE;
    ioPin = 2'h1;
    settle();
    checkReg(7'h48, 8'hd5);
    sbcMode = wake_status_pkg::MODE_STOP;
    ioPin = 2'h3;
    settle();
    checkReg(7'h48, 8'hf5);
    sbcMode = wake_status_pkg::MODE_OTHER;
    ioPin = 2'h0;
    settle();
    checkReg(7'h48, 8'hf5);
    sbcMode = wake_status_pkg::MODE_NORMAL;
    io1Function = wake_status_pkg::IO_FN_OFF;
    settle();
    checkReg(7'h48, 8'hd5);
    // Pin 2 deselected: its level bit must hold although the pin goes high
    ioSelected = 2'h1;
    ioPin = 2'h3;
    settle();
    checkReg(7'h48, 8'hd5);
    ioSelected = 2'h3;
    ioPin = 2'h0;
  endtask

  task automatic testCyclic();
    io1Function = wake_status_pkg::IO_FN_WAKE;
    settle();
    sbcMode = wake_status_pkg::MODE_OTHER;
    wakeCyclic = 3'h1;
    wakeInPin = 3'h4;
    settle();
    checkReg(7'h48, 8'hc5);
    ioPin = 2'h3;
    settle();
    wakeSampleStrobe = 3'h7;
    @(negedge clk);
    wakeSampleStrobe = 3'h0;
    checkReg(7'h48, 8'hc4);
    checkReg(7'h48, 8'hc4);
  endtask

  task automatic testSoftReset();
    wakeCyclic = 3'h0;
    sbcMode = wake_status_pkg::MODE_NORMAL;
    settle();
    checkReg(7'h48, 8'hf4);
    pulseEv(4'hf, 4'hf, 2'h3);
    sbcMode = wake_status_pkg::MODE_OTHER;
    softRst = 1'b1;
    @(negedge clk);
    softRst = 1'b0;
    checkReg(7'h47, 8'h00);
    checkReg(7'h54, 8'h00);
    checkReg(7'h55, 8'h00);
    checkReg(7'h48, 8'hc4);
    modeStrapPin = 1'b0;
    intPullupSense = 1'b0;
    settle();
    checkReg(7'h48, 8'h04);
  endtask

  task automatic testRestart();
    pulseEv(4'ha, 4'h5, 2'h2);
    restartPulse = 1'b1;
    @(negedge clk);
    restartPulse = 1'b0;
    checkReg(7'h47, 8'h20);
    checkReg(7'h54, 8'h0a);
    checkReg(7'h55, 8'h05);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    testReset();
    testSwitchFlags();
    testSetWins();
    testPinWake();
    testLevels();
    testCyclic();
    testSoftReset();
    testRestart();
    final_report();
  end
endmodule
`default_nettype wire
